// ===== rtl/lmc_pkg.sv
// Constants and types shared by the LED pump mode controller
// Contract
// - Pump stays idle until the enable input is seen high.
// - Operation always begins in 1x pass-through mode watching feedback.
// - Feedback low for more than 32 internal clocks moves 1x to 2x.
// - 2x holds until enable toggles, select falls, supply cycles or thermal fault.
// - Select low picks the fixed 50mV feedback reference.
// - Select high picks the resistor-programmed feedback reference.
// - High-current operation shuts down after about 1.6 seconds.
// - After timeout, high current needs enable or select low then high.
// - Over-voltage flag turns every output switch off.
// - Switching resumes by itself once over-voltage flag clears.
// - Over-current flag turns the output switches off.
// - Controller and pump run from an internal 2MHz clock; the state machine and flash timer step on the system clock instead.
// - Enable low is shutdown, enable high is normal operation.

package lmc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int SYS_HZ = 100_000_000;
  localparam int OSC_HZ = 2_000_000;
  localparam int TICK_DIV = SYS_HZ / OSC_HZ;
  localparam int DIV_W = 6;
  localparam int DROP_CYC = 32;
  localparam int DROP_W = 6;
  localparam int TIMEOUT_MS = 1600;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * (SYS_HZ / 1000);
  localparam int TMR_W = 28;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 4;
  localparam int IDX_W = 2;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [IDX_W-1:0] IDX_CTRL = 2'h0;
  localparam logic [IDX_W-1:0] IDX_STATE = 2'h1;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 2'h2;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 2'h3;
  localparam int CTRL_ALLOW_BIT = 0;
  localparam logic CTRL_ALLOW_RST = 1'h1;
  localparam int EV_W = 5;
  localparam int EV_2X = 0;
  localparam int EV_TMO = 1;
  localparam int EV_OVP = 2;
  localparam int EV_OCP = 3;
  localparam int EV_THERM = 4;
  localparam logic [EV_W-1:0] MASK_RST = 5'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_1X = 4'h2,
    ST_2X = 4'h4,
    ST_TMO = 4'h8
  } lmc_state_e;

  typedef struct packed {
    logic rd;
    logic hit;
    logic [IDX_W-1:0] rd_idx;
    logic wr;
    logic [IDX_W-1:0] wr_idx;
    logic [31:0] wdata;
  } lmc_req_s;

  typedef struct packed {
    logic pump_phase;
    logic pump_on;
    logic pass_on;
    logic ref_sel;
  } lmc_drive_s;

endpackage

// ===== rtl/lmc_tick_div.sv
// Divider making the 2MHz internal clock enable from the system clock
`timescale 1ns/10ps
`default_nettype none

module lmc_tick_div (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Internal clock enable
  output logic tick
);

  localparam logic [lmc_pkg::DIV_W-1:0] LAST = lmc_pkg::DIV_W'(lmc_pkg::TICK_DIV - 1);

  logic [lmc_pkg::DIV_W-1:0] cnt_ff;
  logic tick_ff;
  wire wrap = (cnt_ff == LAST);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      cnt_ff <= wrap ? '0 : cnt_ff + 1'b1;
      tick_ff <= wrap;
    end
  end

  assign tick = tick_ff;

endmodule // lmc_tick_div

`default_nettype wire

// ===== rtl/lmc_ahb_port.sv
// AHB-Lite slave front end turning bus phases into register strobes
`timescale 1ns/10ps
`default_nettype none

module lmc_ahb_port (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  // Register strobes
  output var lmc_pkg::lmc_req_s req
);

  logic wr_pend_ff;
  logic [lmc_pkg::IDX_W-1:0] wr_idx_ff;
  logic hready_ff;
  logic hresp_ff;

  wire addr_phase = hsel & htrans[1] & hready;
  wire mapped = (haddr[31:lmc_pkg::ADDR_W] == '0) & (hsize == lmc_pkg::SIZE_WORD);
  wire [lmc_pkg::IDX_W-1:0] idx = haddr[lmc_pkg::ADDR_W-1:2];

  // Reads are served at the address phase, writes in the data phase
  assign req = '{rd: addr_phase & ~hwrite, hit: mapped, rd_idx: idx,
                 wr: wr_pend_ff & hready, wr_idx: wr_idx_ff, wdata: hwdata};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff <= '0;
      hready_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else if (hready) begin
      wr_pend_ff <= addr_phase & hwrite & mapped;
      wr_idx_ff <= idx;
    end
  end

  assign hreadyout = hready_ff;
  assign hresp = hresp_ff;

endmodule // lmc_ahb_port

`default_nettype wire

// ===== rtl/lmc_core.sv
// Mode controller for the LED charge pump with its register file
`timescale 1ns/10ps
`default_nettype none

module lmc_core #(
  parameter int unsigned TIMEOUT_CYC = lmc_pkg::TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Host control pins
  input wire logic enable,
  input wire logic current_select,
  // Analog comparator flags
  input wire logic current_feedback_low,
  input wire logic ovp_flag,
  input wire logic ocp_flag,
  input wire logic thermal_fault,
  input wire logic supply_ok,
  // Switch drive
  output var lmc_pkg::lmc_drive_s drive,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output wire logic hreadyout,
  output wire logic hresp,
  output logic [31:0] hrdata,
  // Interrupt
  output logic irq
);

  // ****************************************
  // Local constants
  // ****************************************
  localparam int TW = lmc_pkg::TMR_W;
  localparam int DW = lmc_pkg::DROP_W;
  localparam int EW = lmc_pkg::EV_W;
  localparam logic [TW-1:0] TMR_LAST = TW'(TIMEOUT_CYC - 1);
  localparam logic [DW-1:0] DROP_LAST = DW'(lmc_pkg::DROP_CYC);

  // ****************************************
  // Declarations
  // ****************************************
  lmc_pkg::lmc_state_e state_ff;
  lmc_pkg::lmc_state_e nxt_state;
  lmc_pkg::lmc_req_s req;
  lmc_pkg::lmc_drive_s drive_ff;
  lmc_pkg::lmc_drive_s nxt_drive;
  logic tick;
  logic [DW-1:0] drop_ff;
  logic [DW-1:0] nxt_drop;
  logic [TW-1:0] timer_ff;
  logic [TW-1:0] nxt_timer;
  logic cs_q_ff;
  logic ovp_q_ff;
  logic ocp_q_ff;
  logic th_q_ff;
  logic allow_ff;
  logic [EW-1:0] mask_ff;
  logic [EW-1:0] status_ff;
  logic [EW-1:0] nxt_status;
  logic [EW-1:0] events;
  logic [31:0] hrdata_ff;
  logic [31:0] rd_word;
  logic irq_ff;

  // ****************************************
  // Internal clock and bus front end
  // ****************************************
  lmc_tick_div u_tick (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tick)
  );

  lmc_ahb_port u_port (
    .sys_clk(sys_clk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .req(req)
  );

  // ****************************************
  // Condition decode
  // ****************************************
  wire st_idle = (state_ff == lmc_pkg::ST_IDLE);
  wire st_1x = (state_ff == lmc_pkg::ST_1X);
  wire st_2x = (state_ff == lmc_pkg::ST_2X);
  wire st_tmo = (state_ff == lmc_pkg::ST_TMO);
  // Enable low, supply loss or software block all mean shutdown
  wire run_ok = enable & supply_ok & allow_ff;
  wire cs_fall = cs_q_ff & ~current_select;
  wire flash_run = (st_1x | st_2x) & current_select;
  wire tmr_done = flash_run & (timer_ff == TMR_LAST);
  wire drop_done = st_1x & tick & current_feedback_low & ~thermal_fault & (drop_ff == DROP_LAST);
  wire leave_2x = cs_fall | thermal_fault;
  // Any protection flag opens every switch
  wire sw_gate = ovp_flag | ocp_flag | thermal_fault;

  // ****************************************
  // Mode state machine
  // ****************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      lmc_pkg::ST_IDLE: begin
        if (run_ok) begin
          nxt_state = lmc_pkg::ST_1X;
        end
      end
      lmc_pkg::ST_1X: begin
        if (!run_ok) begin
          nxt_state = lmc_pkg::ST_IDLE;
        end else if (tmr_done) begin
          nxt_state = lmc_pkg::ST_TMO;
        end else if (drop_done) begin
          nxt_state = lmc_pkg::ST_2X;
        end
      end
      lmc_pkg::ST_2X: begin
        if (!run_ok) begin
          nxt_state = lmc_pkg::ST_IDLE;
        end else if (tmr_done) begin
          nxt_state = lmc_pkg::ST_TMO;
        end else if (leave_2x) begin
          nxt_state = lmc_pkg::ST_1X;
        end
      end
      lmc_pkg::ST_TMO: begin
        if (!run_ok) begin
          nxt_state = lmc_pkg::ST_IDLE;
        end else if (!current_select) begin
          nxt_state = lmc_pkg::ST_1X;
        end
      end
      default: begin
        nxt_state = lmc_pkg::ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // Dropout counter and flash timer
  // ****************************************
  // Counts internal clocks of continuous low feedback, holds at the limit
  assign nxt_drop = (st_1x & current_feedback_low) ?
                    ((tick & (drop_ff != DROP_LAST)) ? drop_ff + 1'b1 : drop_ff) : '0;
  // Runs only while high current is selected, cleared everywhere else
  assign nxt_timer = flash_run ? timer_ff + 1'b1 : '0;

  // ****************************************
  // Switch drive
  // ****************************************
  assign nxt_drive = '{
    pump_phase: (st_2x & ~sw_gate) ? (drive_ff.pump_phase ^ tick) : 1'b0,
    pump_on: st_2x & ~sw_gate,
    pass_on: st_1x & ~sw_gate,
    ref_sel: current_select
  };

  // ****************************************
  // Register file and interrupt
  // ****************************************
  wire wr_ctrl = req.wr & (req.wr_idx == lmc_pkg::IDX_CTRL);
  wire wr_mask = req.wr & (req.wr_idx == lmc_pkg::IDX_IRQ_MASK);
  wire rd_stat = req.rd & req.hit & (req.rd_idx == lmc_pkg::IDX_IRQ_STAT);

  assign events[lmc_pkg::EV_2X] = st_1x & (nxt_state == lmc_pkg::ST_2X);
  assign events[lmc_pkg::EV_TMO] = ~st_tmo & (nxt_state == lmc_pkg::ST_TMO);
  assign events[lmc_pkg::EV_OVP] = ovp_flag & ~ovp_q_ff;
  assign events[lmc_pkg::EV_OCP] = ocp_flag & ~ocp_q_ff;
  assign events[lmc_pkg::EV_THERM] = thermal_fault & ~th_q_ff;

  // A new event in the clearing read cycle stays set
  assign nxt_status = (status_ff & ~{EW{rd_stat}}) | events;

  always_comb begin
    rd_word = '0;
    case (req.rd_idx)
      lmc_pkg::IDX_CTRL: rd_word[lmc_pkg::CTRL_ALLOW_BIT] = allow_ff;
      lmc_pkg::IDX_STATE: rd_word[7:0] = {drive_ff, state_ff};
      lmc_pkg::IDX_IRQ_STAT: rd_word[EW-1:0] = status_ff;
      lmc_pkg::IDX_IRQ_MASK: rd_word[EW-1:0] = mask_ff;
      default: rd_word = '0;
    endcase
    if (!req.hit) begin
      rd_word = '0;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= lmc_pkg::ST_IDLE;
      drop_ff <= '0;
      timer_ff <= '0;
      drive_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      drop_ff <= nxt_drop;
      timer_ff <= nxt_timer;
      drive_ff <= nxt_drive;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cs_q_ff <= 1'b0;
      ovp_q_ff <= 1'b0;
      ocp_q_ff <= 1'b0;
      th_q_ff <= 1'b0;
    end else begin
      cs_q_ff <= current_select;
      ovp_q_ff <= ovp_flag;
      ocp_q_ff <= ocp_flag;
      th_q_ff <= thermal_fault;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      allow_ff <= lmc_pkg::CTRL_ALLOW_RST;
      mask_ff <= lmc_pkg::MASK_RST;
      status_ff <= '0;
      irq_ff <= 1'b0;
      hrdata_ff <= '0;
    end else begin
      if (wr_ctrl) begin
        allow_ff <= req.wdata[lmc_pkg::CTRL_ALLOW_BIT];
      end
      if (wr_mask) begin
        mask_ff <= req.wdata[EW-1:0];
      end
      if (req.rd) begin
        hrdata_ff <= rd_word;
      end
      status_ff <= nxt_status;
      irq_ff <= |(nxt_status & mask_ff);
    end
  end

  assign drive = drive_ff;
  assign hrdata = hrdata_ff;
  assign irq = irq_ff;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  sequence s_ovp_clear;
    ovp_flag ##1 (!ovp_flag && !ocp_flag && !thermal_fault && (st_1x || st_2x));
  endsequence

  sequence s_idle_held;
    st_idle ##1 st_idle;
  endsequence

  property p_idle_until_enable;
    !enable |=> st_idle ##1 (!drive_ff.pass_on && !drive_ff.pump_on);
  endproperty
  a_idle_until_enable: assert property (p_idle_until_enable) else $error("pump active without enable");

  property p_start_1x;
    st_idle && run_ok |=> st_1x ##1 (drive_ff.pass_on || $past(sw_gate));
  endproperty
  a_start_1x: assert property (p_start_1x) else $error("start did not enter 1x");

  property p_dropout;
    $rose(st_2x) |-> $past(drop_ff) == DROP_LAST && $past(current_feedback_low);
  endproperty
  a_dropout: assert property (p_dropout) else $error("2x entered without full dropout");

  property p_hold_2x;
    st_2x && run_ok && !leave_2x && !tmr_done |=> st_2x;
  endproperty
  a_hold_2x: assert property (p_hold_2x) else $error("2x left without exit event");

  property p_ref_low;
    !current_select |=> !drive_ff.ref_sel;
  endproperty
  a_ref_low: assert property (p_ref_low) else $error("fixed reference not selected");

  property p_ref_high;
    current_select |=> drive_ff.ref_sel;
  endproperty
  a_ref_high: assert property (p_ref_high) else $error("programmed reference not selected");

  property p_timeout;
    flash_run && run_ok && timer_ff == TMR_LAST |=> st_tmo ##1 (!drive_ff.pass_on && !drive_ff.pump_on);
  endproperty
  a_timeout: assert property (p_timeout) else $error("flash timeout did not shut down");

  property p_rearm;
    st_tmo && run_ok && current_select |=> st_tmo;
  endproperty
  a_rearm: assert property (p_rearm) else $error("restart without re-arm sequence");

  property p_ovp_off;
    ovp_flag |=> !drive_ff.pass_on && !drive_ff.pump_on;
  endproperty
  a_ovp_off: assert property (p_ovp_off) else $error("switch on during over-voltage");

  property p_ovp_resume;
    s_ovp_clear |=> drive_ff.pass_on == $past(st_1x) && drive_ff.pump_on == $past(st_2x);
  endproperty
  a_ovp_resume: assert property (p_ovp_resume) else $error("no resume after over-voltage");

  property p_ocp_off;
    ocp_flag |=> !drive_ff.pass_on && !drive_ff.pump_on;
  endproperty
  a_ocp_off: assert property (p_ocp_off) else $error("switch on during over-current");

  property p_tick_rate;
    tick |=> !tick [*8];
  endproperty
  a_tick_rate: assert property (p_tick_rate) else $error("internal clock too fast");

  property p_phase_on_tick;
    st_2x && !sw_gate && !tick |=> $stable(drive_ff.pump_phase);
  endproperty
  a_phase_on_tick: assert property (p_phase_on_tick) else $error("pump phase moved off tick");

  property p_shutdown_clear;
    s_idle_held |-> drop_ff == '0 && timer_ff == '0;
  endproperty
  a_shutdown_clear: assert property (p_shutdown_clear) else $error("counters not cleared in shutdown");

endmodule // lmc_core

`default_nettype wire

// ===== tb/lmc_host.sv
// Host model driving the enable and current select pins
`timescale 1ns/10ps
`default_nettype none

module lmc_host #(
  parameter int PWM_HALF = 300
) (
  // Clock
  input wire logic sys_clk,
  // Host commands
  input wire logic run,
  input wire logic pwm,
  input wire logic sel,
  // Pins
  output logic enable,
  output logic current_select
);
  logic [15:0] cnt_ff = 16'h0000;
  logic ph_ff = 1'b0;
  // Square wave on enable; period scaled down, the design does not time it
  always @(posedge sys_clk) begin
    cnt_ff <= (cnt_ff == 16'(PWM_HALF - 1)) ? 16'h0000 : cnt_ff + 16'h0001;
    if (cnt_ff == 16'(PWM_HALF - 1)) begin
      ph_ff <= ~ph_ff;
    end
    enable <= run & (~pwm | ph_ff);
    current_select <= sel;
  end
endmodule // lmc_host

`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the LED pump mode controller
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  localparam int TMO = 4000;
  localparam int TK = 50;
  logic sys_clk = 1'b0, rst = 1'b1, run = 1'b0, pwm = 1'b0, sel = 1'b0;
  logic fb = 1'b0, ovp = 1'b0, ocp = 1'b0, therm = 1'b0, sup = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  wire logic hready, hreadyout, hresp;
  logic [31:0] hrdata;
  logic irq, enable, current_select;
  lmc_pkg::lmc_drive_s drive;
  int n_errors = 0;
  int n_tests = 0;
  int cyc_cnt = 0;
  assign hready = hreadyout;
  always #5 sys_clk = ~sys_clk;

  lmc_host #(.PWM_HALF(300)) host (.sys_clk(sys_clk), .run(run), .pwm(pwm), .sel(sel),
    .enable(enable), .current_select(current_select));
  lmc_core #(.TIMEOUT_CYC(TMO)) uut (.sys_clk(sys_clk), .rst(rst), .enable(enable),
    .current_select(current_select), .current_feedback_low(fb), .ovp_flag(ovp), .ocp_flag(ocp),
    .thermal_fault(therm), .supply_ok(sup), .drive(drive), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 40000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    q = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask

  task automatic st(input logic [3:0] e);
    rchk(32'h4, 32'h0000000F, {28'h0, e});
  endtask

  task automatic go2x;
    @(posedge sys_clk);
    fb <= 1'b1;
    cyc(35 * TK);
    fb <= 1'b0;
    cyc(2);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    chk({28'h0, drive}, 32'h0);
    st(4'h1);
    rchk(32'h0, 32'hFFFFFFFF, 32'h1);
    rchk(32'hC, 32'hFFFFFFFF, 32'h0);
    rchk(32'h10, 32'hFFFFFFFF, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_start;
    @(posedge sys_clk);
    run <= 1'b1;
    cyc(4);
    chk({31'h0, drive.pass_on}, 32'h1);
    chk({31'h0, drive.ref_sel}, 32'h0);
    st(4'h2);
    sel <= 1'b1;
    cyc(4);
    chk({31'h0, drive.ref_sel}, 32'h1);
    sel <= 1'b0;
    cyc(4);
    $display("test start done");
  endtask

  task automatic t_drop;
    logic ph;
    wr(32'hC, 32'h1);
    @(posedge sys_clk);
    fb <= 1'b1;
    cyc(31 * TK);
    chk({31'h0, drive.pump_on}, 32'h0);
    for (int i = 0; i < 4 * TK && drive.pump_on !== 1'b1; i++) cyc(1);
    chk({31'h0, drive.pump_on}, 32'h1);
    ph = drive.pump_phase;
    cyc(TK);
    chk({31'h0, drive.pump_phase}, {31'h0, ~ph});
    chk({31'h0, irq}, 32'h1);
    rchk(32'h8, 32'h1, 32'h1);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    fb <= 1'b0;
    cyc(3 * TK);
    st(4'h4);
    sel <= 1'b1;
    cyc(4);
    st(4'h4);
    sel <= 1'b0;
    cyc(4);
    st(4'h2);
    $display("test dropout done");
  endtask

  task automatic t_exit;
    go2x();
    therm <= 1'b1;
    cyc(4);
    st(4'h2);
    therm <= 1'b0;
    go2x();
    sup <= 1'b0;
    cyc(4);
    st(4'h1);
    sup <= 1'b1;
    go2x();
    run <= 1'b0;
    cyc(4);
    st(4'h1);
    chk({28'h0, drive}, 32'h0);
    fb <= 1'b1;
    run <= 1'b1;
    cyc(20 * TK);
    run <= 1'b0;
    cyc(3);
    run <= 1'b1;
    cyc(20 * TK);
    st(4'h2);
    fb <= 1'b0;
    $display("test exits done");
  endtask

  task automatic t_prot;
    go2x();
    ovp <= 1'b1;
    cyc(4);
    chk({30'h0, drive.pump_on, drive.pass_on}, 32'h0);
    ovp <= 1'b0;
    cyc(4);
    chk({31'h0, drive.pump_on}, 32'h1);
    run <= 1'b0;
    cyc(3);
    run <= 1'b1;
    cyc(4);
    ocp <= 1'b1;
    cyc(4);
    chk({30'h0, drive.pump_on, drive.pass_on}, 32'h0);
    ocp <= 1'b0;
    cyc(4);
    chk({31'h0, drive.pass_on}, 32'h1);
    $display("test protection done");
  endtask

  task automatic t_tmo;
    rchk(32'h8, 32'h1F, 32'h1D);
    sel <= 1'b1;
    cyc(TMO - 20);
    st(4'h2);
    cyc(40);
    st(4'h8);
    chk({31'h0, drive.pass_on}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rchk(32'h8, 32'h2, 32'h2);
    cyc(20);
    st(4'h8);
    sel <= 1'b0;
    cyc(4);
    st(4'h2);
    sel <= 1'b1;
    cyc(4);
    st(4'h2);
    chk({31'h0, drive.pass_on}, 32'h1);
    sel <= 1'b0;
    $display("test timeout done");
  endtask

  task automatic t_pwm;
    pwm <= 1'b1;
    for (int i = 0; i < 700 && enable !== 1'b0; i++) cyc(1);
    cyc(3);
    st(4'h1);
    for (int i = 0; i < 700 && enable !== 1'b1; i++) cyc(1);
    cyc(3);
    chk({31'h0, drive.pass_on}, 32'h1);
    pwm <= 1'b0;
    cyc(4);
    wr(32'h0, 32'h0);
    cyc(3);
    st(4'h1);
    wr(32'h0, 32'h1);
    cyc(3);
    st(4'h2);
    $display("test dimming done");
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    cyc(1);
    t_reset();
    t_start();
    t_drop();
    t_exit();
    t_prot();
    t_tmo();
    t_pwm();
    wrap_up();
  end
endmodule // tb_top

`default_nettype wire
